// >>> logic/cmpr_reset_seq.sv
// Reset sequencer with configuration mismatch check, power-up hold and clock pins
`timescale 1ns/1ns
module cmpr_reset_seq
    import cmpr_pkg::*;
#(
    parameter int unsigned TIMER_TICKS = POWER_UP_TICKS
)(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic powerOnPulse,
    input wire logic master_clear_n,
    input wire logic internal_rc_osc,
    input wire logic osc_in_pin,
    input wire cmpr_cause_s causes,
    input wire cmpr_osc_s oscCfg,
    input wire logic [CFG_W-1:0] flashCfg,
    input wire logic [CFG_W-1:0] liveUpset,
    input wire logic [CFG_W-1:0] shadowUpset,
    output logic deviceReset,
    output logic [7:0] reset_control_reg,
    output logic [CFG_W-1:0] cfgWords,
    output logic osc_out_pin,
    output logic oscOutEn,
    output logic [1:0] portDigitalEn
);

    // Two-stage synchronisers plus a third stage used only for edge detection
    logic [SYNC_N-1:0] sync1_q;
    logic [SYNC_N-1:0] sync2_q;
    logic [SYNC_N-1:0] sync3_q;

    // Pin inputs pass two flops before any logic looks at them
    genvar gi;
    generate
        for (gi = 0; gi < SYNC_N; gi++)
        begin : g_sync
            always_ff @(posedge sys_clk)
            begin
                if (rst)
                begin
                    // Power-on slot resets active, so no false release follows reset
                    sync1_q[gi] <= (gi == S_POR) ? 1'b1 : 1'b0;
                    sync2_q[gi] <= (gi == S_POR) ? 1'b1 : 1'b0;
                    sync3_q[gi] <= (gi == S_POR) ? 1'b1 : 1'b0;
                end
                else
                begin
                    sync1_q[gi] <= gi == S_POR ? powerOnPulse :
                                   gi == S_CLEAR ? master_clear_n :
                                   gi == S_RC ? internal_rc_osc : osc_in_pin;
                    sync2_q[gi] <= sync1_q[gi];
                    sync3_q[gi] <= sync2_q[gi];
                end
            end
        end
    endgenerate

    // Synchronised levels and rising edges
    logic porActive;
    logic clearHigh;
    logic rcTick;
    logic oscRise;
    assign porActive = sync2_q[S_POR];
    assign clearHigh = sync2_q[S_CLEAR];
    assign rcTick = sync2_q[S_RC] & ~sync3_q[S_RC];
    assign oscRise = sync2_q[S_OSC] & ~sync3_q[S_OSC];

    // Power-up timer
    logic timerDone;
    cmpr_pwr_timer #(
        .TICKS(TIMER_TICKS)
    ) u_timer (
        .sys_clk(sys_clk),
        .rst(rst),
        .porActive(porActive),
        .rcTick(rcTick),
        .expired(timerDone)
    );

    // Sequencer, configuration copies and mismatch flag
    cmpr_state_e state_q;
    cmpr_state_e state_d;
    logic [CFG_W-1:0] live_q;
    logic [CFG_W-1:0] live_d;
    logic [CFG_W-1:0] shadow_q;
    logic [CFG_W-1:0] shadow_d;
    logic flag_q;
    logic flag_d;
    logic mismatch;
    logic hardEvent;

    // Shadow holds the complement, so agreement means live equals inverted shadow
    assign mismatch = (live_q != ~shadow_q);
    // Any hard cause while running, mismatch among them
    assign hardEvent = !clearHigh || (|causes) || mismatch;

    // Next-state and data for the sequencer
    always_comb
    begin
        state_d = state_q;
        live_d = live_q;
        shadow_d = shadow_q;
        flag_d = flag_q;
        case (state_q)
            ST_POR:
            begin
                // Wait for the power-on pulse to clear
                if (!porActive)
                begin
                    state_d = ST_TIMER;
                end
            end
            ST_TIMER:
            begin
                // Master clear does not stop the timer; it only delays run
                if (timerDone)
                begin
                    state_d = ST_RELOAD;
                end
            end
            ST_RELOAD:
            begin
                // Fresh copies from flash; shadow stored inverted
                live_d = flashCfg;
                shadow_d = ~flashCfg;
                if (clearHigh)
                begin
                    state_d = ST_RUN;
                end
            end
            ST_RUN:
            begin
                // Disturbances act on the stored copies only while running
                live_d = live_q ^ liveUpset;
                shadow_d = shadow_q ^ shadowUpset;
                if (mismatch)
                begin
                    flag_d = 1'b0;
                end
                if (hardEvent)
                begin
                    state_d = ST_RELOAD;
                end
            end
            default:
            begin
                state_d = ST_POR;
            end
        endcase
        // A new power-on pulse restarts the whole sequence
        if (porActive)
        begin
            state_d = ST_POR;
        end
    end

    // Sequencer registers; flag is touched only by power-on reset and mismatch
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            state_q <= ST_POR;
            live_q <= '0;
            shadow_q <= '1;
            flag_q <= FLAG_RESET;
        end
        else
        begin
            state_q <= state_d;
            live_q <= live_d;
            shadow_q <= shadow_d;
            flag_q <= flag_d;
        end
    end

    // Quarter-rate clock: toggle every second osc-in rising edge
    logic div_q;
    logic div_d;
    logic quarter_q;
    logic quarter_d;
    logic portEn_q;
    logic portEn_d;

    // Divider and pin-function next values
    always_comb
    begin
        div_d = div_q;
        quarter_d = quarter_q;
        if (oscRise)
        begin
            div_d = ~div_q;
            if (div_q == DIV_LAST)
            begin
                quarter_d = ~quarter_q;
            end
        end
        // Port bits give way whenever the pins carry the oscillator
        portEn_d = ~oscCfg.oscPinsClock;
    end

    // Divider and pin-function registers
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            div_q <= 1'b0;
            quarter_q <= 1'b0;
            portEn_q <= 1'b0;
        end
        else
        begin
            div_q <= div_d;
            quarter_q <= quarter_d;
            portEn_q <= portEn_d;
        end
    end

    // Outputs
    assign deviceReset = (state_q != ST_RUN);
    assign reset_control_reg = 8'(flag_q) << FLAG_POS;
    assign cfgWords = live_q;
    assign osc_out_pin = quarter_q & oscCfg.rcMode;
    assign oscOutEn = oscCfg.rcMode;
    assign portDigitalEn = {portEn_q, portEn_q};

    // Reload step followed by release into run
    sequence s_reload_release;
        state_q == ST_RELOAD && clearHigh && !porActive ##1 state_q == ST_RUN;
    endsequence

    a_mismatch_resets: assert property (@(posedge sys_clk) disable iff (rst)
        state_q == ST_RUN && mismatch && !porActive |=> state_q == ST_RELOAD)
        else $error("mismatch did not reset");
    a_flag_cleared: assert property (@(posedge sys_clk) disable iff (rst)
        state_q == ST_RUN && mismatch |=> reset_control_reg == 8'h00)
        else $error("mismatch flag not cleared");
    a_flag_kept: assert property (@(posedge sys_clk) disable iff (rst)
        !(state_q == ST_RUN && mismatch) |=> flag_q == $past(flag_q))
        else $error("flag changed without mismatch");
    a_cause_resets: assert property (@(posedge sys_clk) disable iff (rst)
        state_q == ST_RUN && (|causes) && !porActive |=> deviceReset)
        else $error("hard cause did not reset");
    a_reload_words: assert property (@(posedge sys_clk) disable iff (rst)
        state_q == ST_RELOAD |=> cfgWords == $past(flashCfg) && !mismatch)
        else $error("configuration not reloaded");
    a_timer_holds: assert property (@(posedge sys_clk) disable iff (rst)
        !timerDone |-> deviceReset) else $error("ran before timer expiry");
    a_clear_holds: assert property (@(posedge sys_clk) disable iff (rst)
        !clearHigh |=> deviceReset) else $error("ran with master clear low");
    a_release_runs: assert property (@(posedge sys_clk) disable iff (rst)
        state_q == ST_RELOAD && clearHigh && !porActive |-> s_reload_release)
        else $error("no start after master clear release");
    a_quarter_rate: assert property (@(posedge sys_clk) disable iff (rst)
        oscRise && div_q |=> quarter_q != $past(quarter_q))
        else $error("quarter clock missed toggle");
    a_port_off: assert property (@(posedge sys_clk) disable iff (rst)
        oscCfg.oscPinsClock |=> portDigitalEn == 2'b00)
        else $error("port bits left on");

endmodule

// >>> logic/cmpr_pkg.sv
// Shared constants and carrier types for the reset and configuration-check block
package cmpr_pkg;

    // Width of one configuration word
    localparam int CFG_W = 16;
    // Oscillator edges counted before the power-up timer expires
    localparam int POWER_UP_TICKS = 1024;
    // Position of the mismatch flag inside the reset control byte
    localparam int FLAG_POS = 5;
    // Flag value after a power-on reset: no mismatch seen
    localparam logic FLAG_RESET = 1'b1;
    // Osc-in edges per half period of the quarter-rate clock, minus one
    localparam logic DIV_LAST = 1'b1;
    // Number of pin-side inputs passed through synchronisers
    localparam int SYNC_N = 4;
    // Synchroniser slot of each pin input
    localparam int S_POR = 0;
    localparam int S_CLEAR = 1;
    localparam int S_RC = 2;
    localparam int S_OSC = 3;

    // Sequencer states
    typedef enum logic [1:0] {ST_POR, ST_TIMER, ST_RELOAD, ST_RUN} cmpr_state_e;

    // Soft-side hard reset causes, all on the system clock
    typedef struct packed {
        logic watchdogTimeout;
        logic resetInstr;
        logic stackEvent;
    } cmpr_cause_s;

    // Oscillator pin configuration
    typedef struct packed {
        logic rcMode;
        logic oscPinsClock;
    } cmpr_osc_s;

endpackage

// >>> logic/cmpr_pwr_timer.sv
// Power-up timer: counts internal RC oscillator edges after the power-on pulse
`timescale 1ns/1ns
module cmpr_pwr_timer
    import cmpr_pkg::*;
#(
    parameter int unsigned TICKS = POWER_UP_TICKS
)(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic porActive,
    input wire logic rcTick,
    output logic expired
);

    localparam int CW = $clog2(TICKS + 1);
    localparam logic [CW-1:0] LAST = CW'(TICKS);

    // Count of RC edges since the power-on pulse cleared
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;

    // Next count: restart under the power-on pulse, step on each RC edge until LAST
    always_comb
    begin
        cnt_d = cnt_q;
        if (porActive)
        begin
            cnt_d = '0;
        end
        else if (rcTick && cnt_q != LAST)
        begin
            // No enable input exists, so the timer can never be turned off
            cnt_d = cnt_q + CW'(1);
        end
    end

    // Counter register
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            cnt_q <= '0;
        end
        else
        begin
            cnt_q <= cnt_d;
        end
    end

    assign expired = (cnt_q == LAST);

    // Power-on pulse always restarts the count
    a_por_restart: assert property (@(posedge sys_clk) disable iff (rst)
        porActive |=> cnt_q == '0) else $error("timer not restarted by power-on");

    // Count advances on an RC edge even with master clear low
    a_timer_steps: assert property (@(posedge sys_clk) disable iff (rst)
        !porActive && rcTick && !expired |=> cnt_q == $past(cnt_q) + CW'(1))
        else $error("timer missed an RC edge");

endmodule

// >>> verification/cmpr_pin_model.sv
// Pin-side model: power-on source, master clear switch and the two oscillators
`timescale 1ns/1ns
module cmpr_pin_model
(
    input wire logic sys_clk,
    input wire logic porHold,
    input wire logic clearHold,
    input wire logic rcRun,
    output logic powerOnPulse,
    output logic master_clear_n,
    output logic internal_rc_osc,
    output logic osc_in_pin
);
    // Divider for the RC oscillator, one toggle every third edge
    logic [1:0] rcCnt;
    // Divider for the osc-in pin, well below half the system rate
    logic [1:0] oscCnt;

    // Power comes up with the pulse high and the switch pressed
    initial
    begin
        powerOnPulse = 1'b1;
        master_clear_n = 1'b0;
        internal_rc_osc = 1'b0;
        osc_in_pin = 1'b0;
        rcCnt = 2'h0;
        oscCnt = 2'h0;
    end

    // Pins move just after each rising edge, like a slow board-level source
    always @(posedge sys_clk)
    begin
        powerOnPulse <= porHold;
        // The switch is let go by the outside party only
        master_clear_n <= !clearHold;
        oscCnt <= oscCnt + 2'h1;
        if (oscCnt == 2'h3)
        begin
            osc_in_pin <= !osc_in_pin;
        end
        // A stopped RC source freezes the timer, which shows whose clock it uses
        if (rcRun)
        begin
            rcCnt <= (rcCnt == 2'h2) ? 2'h0 : rcCnt + 2'h1;
            if (rcCnt == 2'h2)
            begin
                internal_rc_osc <= !internal_rc_osc;
            end
        end
    end
endmodule

// >>> verification/cmpr_reset_seq_tb.sv
// Self-checking bench for the reset sequencer and clock pins
`timescale 1ns/1ns
`define CHK(nm, exp, got) \
    begin \
        comparisons++; \
        if ((got) !== (exp)) \
        begin \
            error_cnt++; \
            $display("unexpected %s: expected %h, seen %h", nm, exp, got); \
        end \
    end
module cmpr_reset_seq_tb;
    import cmpr_pkg::*;
    // Short timer keeps the run brief
    localparam int unsigned TT = 4;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic porHold = 1'b1;
    logic clearHold = 1'b0;
    logic rcRun = 1'b1;
    logic powerOnPulse;
    logic master_clear_n;
    logic internal_rc_osc;
    logic osc_in_pin;
    cmpr_cause_s causes = '0;
    cmpr_osc_s oscCfg = '0;
    logic [CFG_W-1:0] flashCfg = 16'h5a3c;
    logic [CFG_W-1:0] liveUpset = 16'h0000;
    logic [CFG_W-1:0] shadowUpset = 16'h0000;
    logic deviceReset;
    logic [7:0] reset_control_reg;
    logic [CFG_W-1:0] cfgWords;
    logic osc_out_pin;
    logic oscOutEn;
    logic [1:0] portDigitalEn;
    int error_cnt = 0;
    int comparisons = 0;
    int cycles = 0;

    cmpr_pin_model pins (.sys_clk(sys_clk), .porHold(porHold), .clearHold(clearHold),
        .rcRun(rcRun), .powerOnPulse(powerOnPulse), .master_clear_n(master_clear_n),
        .internal_rc_osc(internal_rc_osc), .osc_in_pin(osc_in_pin));

    cmpr_reset_seq #(.TIMER_TICKS(TT)) uut (.sys_clk(sys_clk), .rst(rst),
        .powerOnPulse(powerOnPulse), .master_clear_n(master_clear_n),
        .internal_rc_osc(internal_rc_osc), .osc_in_pin(osc_in_pin), .causes(causes),
        .oscCfg(oscCfg), .flashCfg(flashCfg), .liveUpset(liveUpset),
        .shadowUpset(shadowUpset), .deviceReset(deviceReset),
        .reset_control_reg(reset_control_reg), .cfgWords(cfgWords),
        .osc_out_pin(osc_out_pin), .oscOutEn(oscOutEn), .portDigitalEn(portDigitalEn));

    // 50 MHz system clock
    initial
    begin
        forever #10 sys_clk = !sys_clk;
    end

    // Hang guard; the whole run needs well under a thousand cycles
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            error_cnt++;
            wrap_up();
        end
    end

    // Prints the counts and the verdict, then stops
    task automatic wrap_up();
        $display("comparisons %0d, mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Waits, bounded, for the internal reset to reach a level
    task automatic wait_rst(input logic val, input int maxc);
        int n;
        n = 0;
        while (deviceReset !== val && n < maxc)
        begin
            @(posedge sys_clk);
            n++;
        end
        `CHK("reset level in time", val, deviceReset)
    endtask

    // Timer ticks only on RC edges and only after the pulse ends
    task automatic t_powerup();
        repeat (60) @(posedge sys_clk);
        `CHK("reset while pulse high", 1'b1, deviceReset)
        porHold <= 1'b0;
        rcRun <= 1'b0;
        repeat (60) @(posedge sys_clk);
        `CHK("reset with RC stopped", 1'b1, deviceReset)
        `CHK("flag after power-up", 8'h20, reset_control_reg)
        rcRun <= 1'b1;
        wait_rst(1'b0, 120);
        `CHK("words loaded", 16'h5a3c, cfgWords)
        $display("power-up test done");
    endtask

    // Switch held low through a fresh timer run, then released
    task automatic t_master_clear_n();
        clearHold <= 1'b1;
        wait_rst(1'b1, 6);
        porHold <= 1'b1;
        repeat (5) @(posedge sys_clk);
        porHold <= 1'b0;
        repeat (80) @(posedge sys_clk);
        `CHK("reset while switch low", 1'b1, deviceReset)
        clearHold <= 1'b0;
        wait_rst(1'b0, 7);
        $display("master clear test done");
    endtask

    // Single-bit upsets in the live word and in its shadow
    task automatic t_mismatch();
        flashCfg <= 16'hc35a;
        liveUpset <= 16'h0010;
        @(posedge sys_clk);
        liveUpset <= 16'h0000;
        wait_rst(1'b1, 4);
        `CHK("flag cleared", 8'h00, reset_control_reg)
        wait_rst(1'b0, 8);
        `CHK("words after mismatch", 16'hc35a, cfgWords)
        repeat (10) @(posedge sys_clk);
        `CHK("no false mismatch", 1'b0, deviceReset)
        shadowUpset <= 16'h8000;
        @(posedge sys_clk);
        shadowUpset <= 16'h0000;
        wait_rst(1'b1, 4);
        wait_rst(1'b0, 8);
        $display("mismatch test done");
    endtask

    // Each soft cause restarts, reloads and leaves the flag alone
    task automatic t_causes();
        for (int i = 0; i < 3; i++)
        begin
            flashCfg <= 16'h0f00 + 16'(i);
            causes <= cmpr_cause_s'(3'h1 << i);
            @(posedge sys_clk);
            causes <= '0;
            wait_rst(1'b1, 4);
            wait_rst(1'b0, 8);
            `CHK("words after cause", 16'h0f00 + 16'(i), cfgWords)
            `CHK("flag kept", 8'h00, reset_control_reg)
        end
        $display("cause test done");
    endtask

    // Quarter clock period is four osc-in periods of eight cycles
    task automatic t_clocks();
        int n;
        logic prev;
        logic rise;
        oscCfg <= '{rcMode: 1'b1, oscPinsClock: 1'b1};
        repeat (4) @(posedge sys_clk);
        `CHK("port bits off", 2'b00, portDigitalEn)
        `CHK("osc out driven", 1'b1, oscOutEn)
        // Edges from one pin rise to the next; the first lap only finds a rise
        prev = osc_out_pin;
        n = 0;
        for (int k = 0; k < 3; k++)
        begin
            n = 0;
            rise = 1'b0;
            while (!rise && n < 80)
            begin
                @(posedge sys_clk);
                n++;
                rise = (prev === 1'b0 && osc_out_pin === 1'b1);
                prev = osc_out_pin;
            end
        end
        `CHK("quarter period", 32, n)
        oscCfg <= '0;
        repeat (4) @(posedge sys_clk);
        `CHK("port bits back", 2'b11, portDigitalEn)
        `CHK("osc out idle", 1'b0, osc_out_pin)
        `CHK("osc out released", 1'b0, oscOutEn)
        $display("clock pin test done");
    endtask

    // Main sequence
    initial
    begin
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        t_powerup();
        t_master_clear_n();
        t_mismatch();
        t_causes();
        t_clocks();
        wrap_up();
    end
endmodule
